// file: status_pkg.sv
/*
  Shared constants for the processor and floating-point status word bank:
  register byte offsets on the APB slave, field positions, reset values.
  Assumes a single 20 MHz clock domain and an APB master with 32-bit data.
*/
`default_nettype none

package status_pkg;

  // ----------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PSW = 8'h00;
  localparam logic [7:0] ADDR_FSW_LO = 8'h04;
  localparam logic [7:0] ADDR_FSW_HI = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;

  // ----------------------------------------------------------------
  // processor status word fields
  // ----------------------------------------------------------------
  localparam int PSW_MASK_BIT = 0;
  localparam int PSW_OVF_BIT = 1;
  localparam int PSW_INTERRUPT_RESUME_FLAG_BIT = 2;
  localparam int PSW_INSERTED_OPCODE_FLAG_BIT = 3;
  localparam int PSW_FFP_BIT = 4;
  localparam int PSW_SW_LSB = 14;
  localparam logic [15:0] PSW_WRITE_MASK = 16'hC00F;
  localparam logic [15:0] PSW_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // float status word fields (bit 0 is the lsb of the 64-bit word)
  // ----------------------------------------------------------------
  localparam int FSW_ANY_BIT = 0;
  localparam int FSW_ERR_LSB = 1;
  localparam int FSW_TE_BIT = 5;
  localparam int FSW_ZERO_BIT = 6;
  localparam int FSW_NEG_BIT = 7;
  localparam int FSW_RND_BIT = 8;
  localparam int FSW_ID_LSB = 12;
  localparam int FSW_PAR_BIT = 22;
  localparam int FSW_INP_LSB = 28;
  localparam int FSW_PC_LSB = 33;
  localparam logic [3:0] FSW_ID_VALUE = 4'h0; // arbitrary identification value
  localparam logic [63:0] FSW_RESET = 64'h0000_0000_0000_0000;
  // writable bits: te, z, n, rnd, error flags, inp, fault address
  localparam logic [63:0] FSW_WRITE_MASK = 64'hFFFF_FFFE_F000_01FE;

  // quotient value that wide divides never flag as overflow
  localparam logic [31:0] DIV_MIN_QUOT = 32'hFFFF_8000;

endpackage

`default_nettype wire

// file: fault_latch.sv
/*
  Sticky event latch: set wins over clear in the same cycle.
  Assumes clk/rstn of the status bank.
*/
`default_nettype none

module fault_latch (
  input wire logic clk,
  input wire logic rstn,
  input wire logic set,
  input wire logic clr,
  output logic flag
);
  logic flag_q;
  logic flag_d;

  // ----------------------------------------------------------------
  // next value: a set in the clear cycle is kept
  // ----------------------------------------------------------------
  always_comb begin
    flag_d = flag_q;
    if (clr) begin
      flag_d = 1'b0;
    end
    if (set) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;
endmodule

`default_nettype wire

// file: cpu_status_registers.sv
/*
  Processor status word and floating-point status word of the cpu, updated
  by the execution unit and loaded/read by software over apb.
  Assumes execution-unit strobes are one-cycle pulses synchronous to clk.
*/
`default_nettype none

// Operation
// - overflow mask set and overflow flag rising gives fixed-point trap
// - psw bit 1 holds fixed-point overflow flag
// - psw bit 2 selects restart or resume of interrupted instruction
// - psw bit 3 set when interrupted instruction was inserted
// - psw bit 4 shows floating-point fault pending
// - psw bits 5..13 reserved zero, bits 14..15 software use
// - loading mask and flag together never raises overflow fault
// - compatible instructions count as no overflow; only native ones write psw
// - wide divide quotient of -32768 reports no overflow
// - float bit 0 is or of error flags 1..4
// - float bits 1..4 flag exponent over, under, invalid, mantissa
// - trap enable with any error flag set gives float fault; here only a float instruction completing with errors while te is set raises it
// - float reserved bits 9-11, 16-21, 23-27 read zero
// - float bit 22 reports serial or parallel operation
// - float bits 28..31 hold invalid argument code
// - fault captures first faulting instruction address in 33..63, bit 32 zero
// - float word updated by native and compatible instructions
// - float trap taken when faulting instruction completes
// - compatible loads set zero/negative only for normalized operand
module cpu_status_registers
  import status_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // execution unit: fixed point
  input wire logic ex_done,
  input wire logic ex_native,
  input wire logic ex_overflow,
  input wire logic ex_wide_div,
  input wire logic [31:0] ex_quotient,
  input wire logic ex_psw_load,
  input wire logic [15:0] ex_psw_value,
  input wire logic ex_interrupted,
  input wire logic ex_resume,
  input wire logic ex_inserted,
  // execution unit: floating point
  input wire logic fp_done,
  input wire logic fp_compat,
  input wire logic [3:0] fp_errors,
  input wire logic [3:0] fp_bad_arg,
  input wire logic [30:0] fp_addr,
  input wire logic fp_set_cc,
  input wire logic fp_normalized,
  input wire logic fp_zero,
  input wire logic fp_negative,
  input wire logic fp_parallel,
  input wire logic fault_taken,
  // trap requests to sequencer and status word outputs
  output logic overflow_trap,
  output logic float_trap,
  output logic [15:0] psw_out,
  output logic [63:0] fsw_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] psw_q, psw_d;
  logic [63:0] fsw_q, fsw_d;
  logic ovf_trap_q, ovf_trap_d;
  logic fp_trap_q, fp_trap_d;
  logic [31:0] prdata_q, prdata_d;
  logic fault_pending;
  logic fp_fault_set;
  logic eff_overflow;
  logic fp_err_any;
  logic [63:0] fsw_view;
  logic [31:0] psw_wr;

  wire logic apb_wr = psel && penable && pwrite;
  wire logic apb_rd = psel && penable && !pwrite;

  // byte-lane merge for apb writes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // fixed-point overflow evaluation
  // ----------------------------------------------------------------
  always_comb begin
    // compatible instructions never report overflow
    eff_overflow = ex_done && ex_native && ex_overflow;
    if (ex_wide_div && ex_quotient == DIV_MIN_QUOT) begin
      eff_overflow = 1'b0;
    end
    if (ex_psw_load) begin
      eff_overflow = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // float error evaluation; errors arise only at instruction end
  // ----------------------------------------------------------------
  assign fp_err_any = fp_done && (fp_errors != 4'h0);
  // trap raised as the faulting instruction completes, not deferred
  assign fp_fault_set = fp_err_any && fsw_q[FSW_TE_BIT];

  fault_latch u_pending (
    .clk(clk),
    .rstn(rstn),
    .set(fp_fault_set),
    .clr(fault_taken),
    .flag(fault_pending)
  );

  // ----------------------------------------------------------------
  // processor status word next value
  // ----------------------------------------------------------------
  always_comb begin
    psw_d = psw_q;
    ovf_trap_d = 1'b0;
    // lane merge done on the full word, only the low half is kept
    psw_wr = merge({16'h0000, psw_q}, pwdata, pstrb);
    if (apb_wr && paddr == ADDR_PSW) begin
      psw_d = psw_wr[15:0] & PSW_WRITE_MASK;
    end
    if (ex_done && ex_native) begin
      if (ex_psw_load) begin
        // load of mask and flag: no trap even if both are 1
        psw_d = ex_psw_value & PSW_WRITE_MASK;
      end else if (eff_overflow) begin
        psw_d[PSW_OVF_BIT] = 1'b1;
        ovf_trap_d = psw_q[PSW_MASK_BIT];
      end
    end
    if (ex_interrupted) begin
      psw_d[PSW_INTERRUPT_RESUME_FLAG_BIT] = ex_resume;
      psw_d[PSW_INSERTED_OPCODE_FLAG_BIT] = ex_inserted;
    end
    // follows the pending latch in the same cycle, so a take clears it at once
    psw_d[PSW_FFP_BIT] = fp_fault_set || (fault_pending && !fault_taken);
  end

  // ----------------------------------------------------------------
  // float status word next value
  // ----------------------------------------------------------------
  always_comb begin
    fsw_d = fsw_q;
    fp_trap_d = 1'b0;
    if (apb_wr && paddr == ADDR_FSW_LO) begin
      fsw_d[31:0] = merge(fsw_q[31:0], pwdata, pstrb) & FSW_WRITE_MASK[31:0];
    end
    if (apb_wr && paddr == ADDR_FSW_HI) begin
      fsw_d[63:32] = merge(fsw_q[63:32], pwdata, pstrb) & FSW_WRITE_MASK[63:32];
    end
    // native and compatible float instructions both land here
    if (fp_done) begin
      fsw_d[FSW_ERR_LSB +: 4] = fsw_q[FSW_ERR_LSB +: 4] | fp_errors;
      if (fp_errors[2]) begin
        fsw_d[FSW_INP_LSB +: 4] = fp_bad_arg;
      end
      if (fp_set_cc && (!fp_compat || fp_normalized)) begin
        fsw_d[FSW_ZERO_BIT] = fp_zero;
        fsw_d[FSW_NEG_BIT] = fp_negative;
      end
    end
    // every trap-enabled error traps; only the first address is kept
    if (fp_fault_set) begin
      fp_trap_d = 1'b1;
    end
    if (fp_fault_set && !fault_pending) begin
      fsw_d[63:FSW_PC_LSB] = fp_addr;
    end
    fsw_d[FSW_PC_LSB-1] = 1'b0;
  end

  // ----------------------------------------------------------------
  // read view: derived and reserved bits forced
  // ----------------------------------------------------------------
  always_comb begin
    fsw_view = fsw_q & FSW_WRITE_MASK;
    fsw_view[FSW_ANY_BIT] = |fsw_q[FSW_ERR_LSB +: 4];
    fsw_view[FSW_ID_LSB +: 4] = FSW_ID_VALUE;
    fsw_view[FSW_PAR_BIT] = fp_parallel;
  end

  // ----------------------------------------------------------------
  // apb read data
  // ----------------------------------------------------------------
  always_comb begin
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_PSW: prdata_d = {16'h0000, psw_q};
        ADDR_FSW_LO: prdata_d = fsw_view[31:0];
        ADDR_FSW_HI: prdata_d = fsw_view[63:32];
        ADDR_CTRL: prdata_d = {28'h0000000, fp_trap_q, ovf_trap_q, fault_pending,
                               psw_q[PSW_MASK_BIT]};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      psw_q <= PSW_RESET;
      fsw_q <= FSW_RESET;
      ovf_trap_q <= 1'b0;
      fp_trap_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      psw_q <= psw_d;
      fsw_q <= fsw_d;
      ovf_trap_q <= ovf_trap_d;
      fp_trap_q <= fp_trap_d;
      prdata_q <= prdata_d;
    end
  end

  // zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == ADDR_PSW || paddr == ADDR_FSW_LO ||
                                        paddr == ADDR_FSW_HI || paddr == ADDR_CTRL);
  assign prdata = prdata_q;
  assign overflow_trap = ovf_trap_q;
  assign float_trap = fp_trap_q;
  assign psw_out = psw_q;
  assign fsw_out = fsw_view;

  wire logic unused_rd = apb_rd;
endmodule

`default_nettype wire

// file: status_monitor.sv
/*
  Port-level checks on the status bank.
  Assumes one clock domain; bound into every instance of the bank.
*/
`default_nettype none
module status_monitor
  import status_pkg::*;
(
  input wire logic clk,
  rstn,
  psel,
  penable,
  pwrite,
  ex_done,
  ex_native,
  ex_overflow,
  ex_wide_div,
  ex_psw_load,
  fp_done,
  fault_taken,
  overflow_trap,
  float_trap,
  input wire logic [3:0] fp_errors,
  input wire logic [30:0] fp_addr,
  input wire logic [15:0] psw_out,
  input wire logic [63:0] fsw_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // a software write on the same edge may win, so it is excluded
  wire logic wr = psel & penable & pwrite;
  sequence ovf_s;
    ex_done && ex_native && ex_overflow && !ex_psw_load && !ex_wide_div && !wr;
  endsequence
  sequence flt_s;
    fp_done && (fp_errors != 4'h0) && fsw_out[FSW_TE_BIT] && !wr;
  endsequence
  a_ovf_trap_fires: assert property (ovf_s ##0 psw_out[0] && !psw_out[1] |=> overflow_trap)
    else $error("overflow trap missing");
  a_ovf_flag_set: assert property (ovf_s |=> psw_out[PSW_OVF_BIT])
    else $error("overflow flag not set");
  a_compat_keeps_psw: assert property (ex_done && !ex_native && !wr |=> $stable(psw_out[1:0]))
    else $error("compatible op changed psw");
  a_load_no_trap: assert property (ex_done && ex_psw_load |=> !overflow_trap)
    else $error("trap on psw load");
  a_any_error_or: assert property (fsw_out[0] == (fsw_out[4:1] != 4'h0))
    else $error("summary bit wrong");
  a_reserved_zero: assert property (fsw_out[11:9] == 3'h0 && fsw_out[21:16] == 6'h0
    && fsw_out[27:23] == 5'h0 && !fsw_out[32])
    else $error("reserved float bit set");
  a_float_trap_fires: assert property (flt_s |=> float_trap && psw_out[PSW_FFP_BIT])
    else $error("float trap missing");
  a_pending_holds: assert property ($fell(psw_out[PSW_FFP_BIT]) |-> $past(fault_taken))
    else $error("pending dropped early");
  a_fault_addr_kept: assert property (flt_s ##0 !psw_out[4] |=> fsw_out[63:33] == $past(fp_addr))
    else $error("fault address wrong");
endmodule
bind cpu_status_registers status_monitor mon (.*);
`default_nettype wire

// file: exec_model.sv
/*
  Execution unit stand-in: retires fixed and float ops as one-cycle strobes.
  Assumes the bank's clock; operands go stale once the strobe drops.
*/
`default_nettype none
module exec_model (
  input wire logic clk,
  output logic ex_done,
  ex_native,
  ex_overflow,
  ex_wide_div,
  ex_psw_load,
  ex_interrupted,
  ex_resume,
  ex_inserted,
  fp_done,
  fp_compat,
  fp_set_cc,
  fp_normalized,
  fp_zero,
  fp_negative,
  fp_parallel,
  fault_taken,
  output logic [31:0] ex_quotient,
  output logic [15:0] ex_psw_value,
  output logic [3:0] fp_errors,
  fp_bad_arg,
  output logic [30:0] fp_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // everything quiet at time zero
  initial {ex_done, ex_native, ex_overflow, ex_wide_div, ex_psw_load, ex_interrupted,
    ex_resume, ex_inserted, fp_done, fp_compat, fp_set_cc, fp_normalized, fp_zero,
    fp_negative, fp_parallel, fault_taken, ex_quotient, ex_psw_value, fp_errors,
    fp_bad_arg, fp_addr} = '0;
  // stale overflow, quotient, resume, inserted, error and address operands are inverted so a bank that ignores the strobe is caught
  task automatic fix(input logic nat, ov, wd, ld, input logic [31:0] q,
    input logic [15:0] v);
    @(posedge clk);
    {ex_done, ex_native, ex_overflow, ex_wide_div, ex_psw_load} <= {1'b1, nat, ov, wd, ld};
    {ex_quotient, ex_psw_value} <= {q, v};
    @(posedge clk);
    {ex_done, ex_overflow, ex_quotient} <= {1'b0, !ov, ~q};
  endtask
  task automatic intr(input logic res, ins);
    @(posedge clk);
    {ex_interrupted, ex_resume, ex_inserted} <= {1'b1, res, ins};
    @(posedge clk);
    {ex_interrupted, ex_resume, ex_inserted} <= {1'b0, !res, !ins};
  endtask
  task automatic flt(input logic cmp, input logic [3:0] e, b, cc, input logic [30:0] a);
    @(posedge clk);
    {fp_done, fp_compat, fp_errors, fp_bad_arg, fp_addr} <= {1'b1, cmp, e, b, a};
    {fp_set_cc, fp_normalized, fp_zero, fp_negative} <= cc;
    @(posedge clk);
    {fp_done, fp_errors, fp_addr} <= {1'b0, ~e, ~a};
  endtask
  task automatic take();
    @(posedge clk);
    fault_taken <= 1'b1;
    @(posedge clk);
    fault_taken <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: cpu_status_registers_tb.sv
/*
  Self-checking bench: apb master plus execution unit model.
  Assumes the bank answers with pready and bind of the monitor.
*/
`default_nettype none
module cpu_status_registers_tb
  import status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, overflow_trap, float_trap, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, ex_quotient, rd;
  logic [3:0] pstrb, fp_errors, fp_bad_arg;
  logic [15:0] psw_out, ex_psw_value;
  logic [63:0] fsw_out;
  logic [30:0] fp_addr;
  logic ex_done, ex_native, ex_overflow, ex_wide_div, ex_psw_load, ex_interrupted,
    ex_resume, ex_inserted, fp_done, fp_compat, fp_set_cc, fp_normalized, fp_zero,
    fp_negative, fp_parallel, fault_taken;
  int num_errors, checks, cyc, n_ovf, n_flt;
  cpu_status_registers dut (.*);
  exec_model em (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // trap pulses counted, plus a ceiling on run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (overflow_trap === 1'b1) n_ovf <= n_ovf + 1;
    if (float_trap === 1'b1) n_flt <= n_flt + 1;
    if (cyc == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    {se, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input logic [63:0] g, e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task finish_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b1, ADDR_PSW, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_PSW, 32'h0);
    chk(64'(rd), 64'hC00F);
    apb(1'b1, ADDR_FSW_LO, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_FSW_LO, 32'h0);
    chk(64'(rd), 64'hF000_01FF);
    apb(1'b1, ADDR_FSW_HI, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_FSW_HI, 32'h0);
    chk(64'(rd), 64'hFFFF_FFFE);
    apb(1'b0, 8'h40, 32'h0);
    chk(64'({se, rd}), 64'h1_0000_0000);
    apb(1'b1, ADDR_FSW_HI, 32'h0);
    apb(1'b1, ADDR_PSW, 32'h1);
    em.fix(1'b1, 1'b1, 1'b0, 1'b0, 32'h5, 16'h0);
    @(posedge clk);
    chk(64'(psw_out), 64'h3);
    apb(1'b1, ADDR_PSW, 32'h1);
    em.fix(1'b0, 1'b1, 1'b0, 1'b0, 32'h5, 16'h0);
    em.fix(1'b1, 1'b1, 1'b1, 1'b0, 32'hFFFF_8000, 16'h0);
    em.intr(1'b1, 1'b0);
    @(posedge clk);
    chk(64'(psw_out), 64'h5);
    em.intr(1'b0, 1'b1);
    @(posedge clk);
    chk(64'(psw_out), 64'h9);
    em.fix(1'b1, 1'b0, 1'b0, 1'b1, 32'h0, 16'hFFFF);
    @(posedge clk);
    chk(64'(psw_out), 64'hC00F);
    // each error code in turn, native and compatible alternating
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_FSW_LO, 32'h0);
      em.flt(1'(i), 4'(1 << i), 4'h0, 4'h0, 31'h0);
      @(posedge clk);
      chk(64'(fsw_out[4:0]), 64'((2 << i) | 1));
    end
    em.flt(1'b0, 4'h0, 4'h0, 4'hF, 31'h0);
    em.fp_parallel <= 1'b1;
    repeat (3) @(posedge clk);
    chk(64'({fsw_out[22], fsw_out[7:6]}), 64'h7);
    apb(1'b1, ADDR_FSW_LO, 32'h20);
    em.flt(1'b0, 4'h4, 4'hA, 4'h0, 31'h123_4567);
    @(posedge clk);
    chk(fsw_out, 64'h0246_8ACE_A040_0029);
    chk(64'(psw_out[4]), 64'h1);
    em.flt(1'b1, 4'h9, 4'h0, 4'h0, 31'h7);
    @(posedge clk);
    chk(fsw_out, 64'h0246_8ACE_A040_003B);
    em.take();
    @(posedge clk);
    chk(64'(psw_out[4]), 64'h0);
    chk(64'({n_ovf, n_flt}), {32'h1, 32'h2});
    finish_test();
  end
endmodule
`default_nettype wire
